// >>> rtl/dal_top.sv
// one division of the depressurization actuation logic
// assumes sensor words and other-division votes come from outside the clock domain
//
// Register access over Wishbone and the address map were chosen for this implementation.
`default_nettype none

module dal_top import dal_pkg::*; #(
	parameter int SW = 16,
	parameter logic [1:0] DIV_ID = 2'd0,
	parameter logic [TW-1:0] LVL_CYC = TW'(LVL_SUSTAIN_CYC),
	parameter logic [TW-1:0] PRS_CYC = TW'(PRS_SUSTAIN_CYC),
	parameter logic [NGRP-1:0][TW-1:0] GRP_T = {
		TW'(4 * GRP_STEP_CYC), TW'(3 * GRP_STEP_CYC),
		TW'(2 * GRP_STEP_CYC), TW'(GRP_STEP_CYC), TW'(0)}
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// sensor words, one per redundant channel
	input wire logic [3*SW-1:0] level_i,
	input wire logic [3*SW-1:0] press_i,
	// votes from all divisions, own position ignored
	input wire logic [3:0] div_lvl_vote_i,
	input wire logic [3:0] div_prs_vote_i,
	// firing path feedback
	input wire logic [3*NV-1:0] drv_fb_i,
	input wire logic [NV-1:0] cont_ok_i,
	input wire logic [NV-1:0] dis_sw_i,
	// votes shared with other divisions
	output logic vote_lvl_o,
	output logic vote_prs_o,
	// initiation signals
	output logic lvl_init_o,
	output logic prs_init_o,
	// firing drivers and path state
	output logic [3*NV-1:0] drv_o,
	output logic [NV-1:0] path_fire_o,
	// control room indications
	output logic arm_alarm_o,
	output logic oos_alarm_o,
	output logic [3:0] bypass_ind_o
);

	////////////////////////////////////////////////////////////////
	// input synchronisers

	logic [3*SW-1:0] lvl_m_q, lvl_s_q, prs_m_q, prs_s_q;
	logic [3:0] vl_m_q, vl_s_q, vp_m_q, vp_s_q;
	logic [3*NV-1:0] fb_m_q, fb_s_q;
	logic [NV-1:0] co_m_q, co_s_q, ds_m_q, ds_s_q;

	// two stages on every outside input except the bus and reset
	always_ff @(posedge clk_i) begin
		lvl_m_q <= level_i;
		lvl_s_q <= lvl_m_q;
		prs_m_q <= press_i;
		prs_s_q <= prs_m_q;
		vl_m_q <= div_lvl_vote_i;
		vl_s_q <= vl_m_q;
		vp_m_q <= div_prs_vote_i;
		vp_s_q <= vp_m_q;
		fb_m_q <= drv_fb_i;
		fb_s_q <= fb_m_q;
		co_m_q <= cont_ok_i;
		co_s_q <= co_m_q;
		ds_m_q <= dis_sw_i;
		ds_s_q <= ds_m_q;
	end

	////////////////////////////////////////////////////////////////
	// register state

	logic inhibit_q;
	logic byp_en_q;
	logic [1:0] byp_div_q;
	logic [SW-1:0] lvl_sp_q, prs_sp_q;
	logic [3:0] sys_arm_q, sys_used_q;
	logic sys_init_q;
	logic vlv_armed_q;
	logic [4:0] vlv_sel_q;
	logic [NV-1:0] man_fire_q;
	logic tst_en_q;
	logic [1:0] tst_drv_q;
	logic [4:0] tst_vlv_q;
	logic [2:0] tst_seen_q;

	logic wr, req, tst_all;
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i[0];

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// control and setpoints; one bypass index so only one division
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhibit_q <= 1'b0;
			byp_en_q <= 1'b0;
			byp_div_q <= 2'd0;
			lvl_sp_q <= LVL_SP_RST[SW-1:0];
			prs_sp_q <= PRS_SP_RST[SW-1:0];
		end else if (wr) begin
			if (wb_adr_i == REG_CTRL) begin
				inhibit_q <= wb_dat_i[CTRL_INHIBIT];
				byp_en_q <= wb_dat_i[CTRL_BYP_EN];
				byp_div_q <= wb_dat_i[CTRL_BYP_DIV +: 2];
			end else if (wb_adr_i == REG_LVL_SP) begin
				lvl_sp_q <= wb_dat_i[SW-1:0];
			end else if (wb_adr_i == REG_PRS_SP) begin
				prs_sp_q <= wb_dat_i[SW-1:0];
			end
		end
	end

	// system arm and fire per division; fire counts only after arm
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_arm_q <= 4'h0;
			sys_used_q <= 4'h0;
		end else if (wr && wb_adr_i == REG_SYS_MAN) begin
			sys_arm_q <= sys_arm_q | wb_dat_i[3:0];
			sys_used_q <= sys_used_q | (sys_arm_q & wb_dat_i[MAN_FIRE +: 4]);
		end
	end

	// any two divisions used seals the system initiation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_init_q <= 1'b0;
		end else if (cnt4(sys_used_q) >= 3'd2) begin
			sys_init_q <= 1'b1;
		end
	end

	// single valve: arm selects, a later separate fire opens it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vlv_armed_q <= 1'b0;
			vlv_sel_q <= 5'd0;
			man_fire_q <= '0;
		end else if (wr && wb_adr_i == REG_VLV_MAN) begin
			if (wb_dat_i[VLV_ARM]) begin
				vlv_armed_q <= 1'b1;
				vlv_sel_q <= wb_dat_i[4:0];
			end else if (wb_dat_i[VLV_FIRE] && vlv_armed_q) begin
				vlv_armed_q <= 1'b0;
				if (32'(vlv_sel_q) < NV) begin
					man_fire_q[vlv_sel_q] <= 1'b1;
				end
			end else begin
				vlv_armed_q <= 1'b0; // a write with neither disarms
			end
		end
	end

	// driver test selection; a new selection clears closure history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tst_en_q <= 1'b0;
			tst_drv_q <= 2'd0;
			tst_vlv_q <= 5'd0;
			tst_seen_q <= 3'b000;
		end else if (wr && wb_adr_i == REG_DRV_TEST) begin
			tst_en_q <= wb_dat_i[0];
			tst_drv_q <= wb_dat_i[TST_DRV +: 2];
			tst_vlv_q <= wb_dat_i[TST_VLV +: 5];
			tst_seen_q <= 3'b000;
		end else if (tst_en_q && 32'(tst_vlv_q) < NV) begin
			tst_seen_q <= tst_seen_q | fb_s_q[3*tst_vlv_q +: 3];
		end
	end

	////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [2:0] cnt4(input logic [3:0] v);
		cnt4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
	endfunction

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	// group of a valve: relief 0-4, 5-9, squib 10-12, 13-15, 16-17
	function automatic int grp_of(input int v);
		if (v < 5) begin
			grp_of = 0;
		end else if (v < FIRST_SQUIB) begin
			grp_of = 1;
		end else if (v < 13) begin
			grp_of = 2;
		end else if (v < 16) begin
			grp_of = 3;
		end else begin
			grp_of = 4;
		end
	endfunction

	logic [3:0] byp_mask;
	assign byp_mask = byp_en_q ? ~(4'b0001 << byp_div_q) : 4'hF;

	////////////////////////////////////////////////////////////////
	// three redundant channels

	logic [2:0] ch_lvl_trip, ch_prs_trip, ch_lvl_lat, ch_prs_lat;
	logic [NGRP-1:0] ch_grp [3];

	for (genvar c = 0; c < 3; c++) begin : g_ch
		logic [SW-1:0] lvl, prs;
		logic [3:0] vl, vp;
		logic dec_l, dec_p, auto_go, go;
		logic [TW-1:0] tl_q, tp_q, seq_cnt_q;
		logic lat_l_q, lat_p_q;
		dal_seq_t st_q;

		assign lvl = lvl_s_q[c*SW +: SW];
		assign prs = prs_s_q[c*SW +: SW];
		assign ch_lvl_trip[c] = lvl < lvl_sp_q;
		assign ch_prs_trip[c] = prs > prs_sp_q;

		// own vote takes its place among the shared ones
		always_comb begin
			vl = vl_s_q;
			vp = vp_s_q;
			vl[DIV_ID] = ch_lvl_trip[c];
			vp[DIV_ID] = ch_prs_trip[c];
		end

		// two of the four, or of the three left when one is bypassed
		assign dec_l = cnt4(vl & byp_mask) >= 3'd2;
		assign dec_p = cnt4(vp & byp_mask) >= 3'd2;

		// sustain timers restart from zero whenever the decision drops
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				tl_q <= '0;
				lat_l_q <= 1'b0;
			end else if (!dec_l) begin
				tl_q <= '0;
			end else if (tl_q >= LVL_CYC - 1'b1) begin
				lat_l_q <= 1'b1;
			end else begin
				tl_q <= tl_q + 1'b1;
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				tp_q <= '0;
				lat_p_q <= 1'b0;
			end else if (!dec_p) begin
				tp_q <= '0;
			end else if (tp_q >= PRS_CYC - 1'b1) begin
				lat_p_q <= 1'b1;
			end else begin
				tp_q <= tp_q + 1'b1;
			end
		end

		assign ch_lvl_lat[c] = lat_l_q;
		assign ch_prs_lat[c] = lat_p_q;

		// inhibit holds back automatic starts, manual initiation still acts
		assign auto_go = (lat_l_q | lat_p_q) & ~inhibit_q;
		assign go = auto_go | sys_init_q;

		// one running count drives the five group timers
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				st_q <= DAL_IDLE;
				seq_cnt_q <= '0;
			end else begin
				case (st_q)
					DAL_IDLE: begin
						if (go) begin
							st_q <= DAL_RUN;
						end
					end
					DAL_RUN: begin
						if (seq_cnt_q >= GRP_T[NGRP-1]) begin
							st_q <= DAL_DONE;
						end else begin
							seq_cnt_q <= seq_cnt_q + 1'b1;
						end
					end
					default: begin
						st_q <= DAL_DONE; // sealed in until reset
					end
				endcase
			end
		end

		for (genvar g = 0; g < NGRP; g++) begin : g_grp
			assign ch_grp[c][g] = (st_q != DAL_IDLE) && (seq_cnt_q >= GRP_T[g]);
		end
	end

	////////////////////////////////////////////////////////////////
	// channel majority and firing paths

	logic [NGRP-1:0] grp_open;
	logic [NV-1:0] cmd, path_d;
	logic [3*NV-1:0] drv_d;

	for (genvar g = 0; g < NGRP; g++) begin : g_vote
		assign grp_open[g] = maj3({ch_grp[2][g], ch_grp[1][g], ch_grp[0][g]});
	end

	// every driver of a valve closes together; a test closes only one
	for (genvar v = 0; v < NV; v++) begin : g_vlv
		localparam int ND = (v >= FIRST_SQUIB) ? 3 : 2;
		assign cmd[v] = grp_open[grp_of(v)] | man_fire_q[v];
		for (genvar k = 0; k < 3; k++) begin : g_drv
			if (k < ND) begin : g_used
				assign drv_d[3*v+k] = cmd[v] |
					(tst_en_q && 32'(tst_vlv_q) == v && 32'(tst_drv_q) == k);
			end else begin : g_none
				assign drv_d[3*v+k] = 1'b0;
			end
		end
		// valve fires only when drivers, continuity and switch all conduct
		assign path_d[v] = &fb_s_q[3*v +: ND] & co_s_q[v] & ~ds_s_q[v];
	end

	// outputs straight from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_o <= '0;
			path_fire_o <= '0;
			vote_lvl_o <= 1'b0;
			vote_prs_o <= 1'b0;
			lvl_init_o <= 1'b0;
			prs_init_o <= 1'b0;
			arm_alarm_o <= 1'b0;
			oos_alarm_o <= 1'b0;
			bypass_ind_o <= 4'h0;
		end else begin
			drv_o <= drv_d;
			path_fire_o <= path_d & cmd;
			vote_lvl_o <= maj3(ch_lvl_trip);
			vote_prs_o <= maj3(ch_prs_trip);
			lvl_init_o <= maj3(ch_lvl_lat);
			prs_init_o <= maj3(ch_prs_lat);
			arm_alarm_o <= vlv_armed_q | (|sys_arm_q);
			oos_alarm_o <= |ds_s_q;
			bypass_ind_o <= ~byp_mask;
		end
	end

	////////////////////////////////////////////////////////////////
	// read path

	assign tst_all = (32'(tst_vlv_q) >= FIRST_SQUIB) ? &tst_seen_q : &tst_seen_q[1:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			if (wb_adr_i == REG_CTRL) begin
				wb_dat_o <= 32'({byp_div_q, byp_en_q, 3'b000, inhibit_q});
			end else if (wb_adr_i == REG_LVL_SP) begin
				wb_dat_o <= 32'(lvl_sp_q);
			end else if (wb_adr_i == REG_PRS_SP) begin
				wb_dat_o <= 32'(prs_sp_q);
			end else if (wb_adr_i == REG_SYS_MAN) begin
				wb_dat_o <= 32'({sys_init_q, sys_used_q, sys_arm_q});
			end else if (wb_adr_i == REG_VLV_MAN) begin
				wb_dat_o <= 32'({vlv_armed_q, 3'b000, vlv_sel_q});
			end else if (wb_adr_i == REG_DRV_TEST) begin
				wb_dat_o <= 32'({tst_all, tst_seen_q, tst_vlv_q, 3'b000, tst_drv_q, tst_en_q});
			end else if (wb_adr_i == REG_STATUS) begin
				wb_dat_o <= 32'({grp_open, ch_prs_lat, ch_lvl_lat, ch_prs_trip, ch_lvl_trip});
			end else if (wb_adr_i == REG_VLV_STAT) begin
				wb_dat_o <= 32'(cmd);
			end else if (wb_adr_i == REG_OOS) begin
				wb_dat_o <= 32'(ds_s_q);
			end else begin
				wb_dat_o <= 32'h0000_0000; // unmapped reads zero
			end
		end
	end

endmodule

`default_nettype wire

// >>> rtl/dal_pkg.sv
// constants shared by the divisional depressurization actuation logic
// assumes a 125 MHz clock and a classic wishbone register bus
// Notes on behaviour
// - single valve opens only after arm, then fire
// - valve arm action raises a plant alarm
// - two divisions armed and fired seal system initiation
// - control room inhibit blocks automatic initiation
// - division makes level and pressure votes, shares them
// - two of four voting, two of three bypassed
// - one sensor division bypass, reported
// - three redundant channels compute trips, voting, sustain and group timers
// - level below setpoint gives level trip
// - pressure above setpoint gives pressure trip
// - trip drop clears its sustain timer
// - level trip held 10 s seals initiation
// - pressure trip held 60 min seals initiation
// - level initiation starts the five group timers
// - pressure initiation starts the same group timers
// - series drivers, continuity, disable switch all conduct
// - drivers tested singly, closure indicated
// - disable switch affects own valve, alarms
// - no trip logic division bypass exists
// - relief groups then squib groups, successive delays
// - inhibit blocks sequenced start of all valves, except by manual system initiation
`default_nettype none

package dal_pkg;

	localparam longint unsigned CLK_HZ = 125_000_000;
	localparam int TW = 40; // timer width, holds one hour of cycles

	// sustain times as printed, and derived cycle counts
	localparam longint unsigned LVL_SUSTAIN_S = 10;
	localparam longint unsigned PRS_SUSTAIN_MIN = 60;
	localparam longint unsigned LVL_SUSTAIN_CYC = LVL_SUSTAIN_S * CLK_HZ;
	localparam longint unsigned PRS_SUSTAIN_CYC = PRS_SUSTAIN_MIN * 60 * CLK_HZ;

	// group delay step from initiation, plain default
	localparam longint unsigned GRP_STEP_S = 10;
	localparam longint unsigned GRP_STEP_CYC = GRP_STEP_S * CLK_HZ;

	// valve layout: ten relief valves then eight squib valves
	localparam int NV = 18;
	localparam int NGRP = 5;
	localparam int FIRST_SQUIB = 10;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LVL_SP = 8'h04;
	localparam logic [7:0] REG_PRS_SP = 8'h08;
	localparam logic [7:0] REG_SYS_MAN = 8'h0C;
	localparam logic [7:0] REG_VLV_MAN = 8'h10;
	localparam logic [7:0] REG_DRV_TEST = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_VLV_STAT = 8'h1C;
	localparam logic [7:0] REG_OOS = 8'h20;

	// field positions
	localparam int CTRL_INHIBIT = 0;
	localparam int CTRL_BYP_EN = 4;
	localparam int CTRL_BYP_DIV = 5; // two bits
	localparam int MAN_FIRE = 4; // fire nibble above arm nibble
	localparam int VLV_ARM = 8;
	localparam int VLV_FIRE = 9;
	localparam int TST_DRV = 1; // two bits
	localparam int TST_VLV = 8; // five bits

	// reset values
	localparam logic [15:0] LVL_SP_RST = 16'h0000;
	localparam logic [15:0] PRS_SP_RST = 16'hFFFF;

	// sequencer states
	typedef enum logic [1:0] {
		DAL_IDLE = 2'b00,
		DAL_RUN = 2'b01,
		DAL_DONE = 2'b11
	} dal_seq_t;

endpackage

`default_nettype wire

// >>> tb/dal_valve_unit.sv
// firing side model: load drivers close one cycle after their command
// assumes the bench asks for disable switches through off_i
`default_nettype none

module dal_valve_unit import dal_pkg::*; (
	// clock
	input wire logic clk_i,
	// commands from the division
	input wire logic [3*NV-1:0] drv_i,
	input wire logic [NV-1:0] off_i,
	// feedback to the division
	output logic [3*NV-1:0] fb_o,
	output logic [NV-1:0] cont_o,
	output logic [NV-1:0] dis_o
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////
	// a driver reports closed only once it really conducts, never early
	always_ff @(posedge clk_i) begin
		fb_o <= drv_i;
	end

	// continuity always good; the switch opens only its own path
	assign cont_o = '1;
	assign dis_o = off_i;
endmodule

`default_nettype wire

// >>> tb/dal_top_monitor.sv
// port assertions for one actuation division
// assumes bind to dal_top with group delays ten cycles apart
`default_nettype none

module dal_top_monitor import dal_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// valve side
	input wire logic [NV-1:0] dis_sw_i,
	input wire logic [3*NV-1:0] drv_o,
	input wire logic [NV-1:0] path_fire_o,
	// indications
	input wire logic lvl_init_o,
	input wire logic prs_init_o,
	input wire logic oos_alarm_o,
	input wire logic [3:0] bypass_ind_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////
	// bus answers once per request
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	// seal in: level initiation never drops once issued, pressure initiation holds eight cycles after its rise
	a_lvl_seal: assert property (lvl_init_o |=> lvl_init_o)
		else $error("level initiation dropped");
	a_prs_seal: assert property ($rose(prs_init_o) |=> prs_init_o [*8])
		else $error("pressure initiation dropped");
	// relief valves have two drivers only
	a_relief_two: assert property ((drv_o[29:0] & {10{3'h4}}) == 30'h0)
		else $error("third driver on relief valve");
	// a path fires only behind its own commanded drivers
	a_fire_path: assert property ($rose(path_fire_o[0]) |-> $past(drv_o[1:0]) == 2'h3)
		else $error("path fired without drivers");
	a_own_path: assert property (dis_sw_i[0] [*4] |-> !path_fire_o[0])
		else $error("disabled path still fires");
	a_oos_alarm: assert property (dis_sw_i[0] [*4] |-> oos_alarm_o)
		else $error("disable switch not alarmed");
	a_bypass_one: assert property ($onehot0(bypass_ind_o))
		else $error("more than one division bypassed");
	// reset quiets drivers, both initiations and ack, even at its release
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> drv_o == '0 && !lvl_init_o && !prs_init_o && !wb_ack_o)
		else $error("output active after reset");

	// main scenarios
	c_lvl: cover property ($rose(lvl_init_o));
	c_prs: cover property ($rose(prs_init_o));
	c_oos: cover property ($rose(oos_alarm_o));
endmodule

bind dal_top dal_top_monitor u_mon (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .dis_sw_i(dis_sw_i), .drv_o(drv_o),
	.path_fire_o(path_fire_o), .lvl_init_o(lvl_init_o), .prs_init_o(prs_init_o),
	.oos_alarm_o(oos_alarm_o), .bypass_ind_o(bypass_ind_o)
);

`default_nettype wire

// >>> tb/dal_top_bench.sv
// self-checking bench for one actuation division
// assumes shortened sustain counts and the valve unit model on the firing side
`default_nettype none

module dal_top_bench import dal_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LC = 20;
	localparam int PC = 40;
	localparam int GS = 10;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [3:0] wb_sel_i = 4'h1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	logic [47:0] level_i = '0, press_i = '0;
	logic [3:0] lv_i = 4'h0, pv_i = 4'h0, bypass_ind_o;
	logic [3*NV-1:0] drv_fb_i, drv_o;
	logic [NV-1:0] cont_ok_i, dis_sw_i, path_fire_o, dis_req = '0;
	logic vote_lvl_o, vote_prs_o, lvl_init_o, prs_init_o, arm_alarm_o, oos_alarm_o;
	int failures = 0, samples_checked = 0, n;
	// reset values: address beside expected read data
	logic [39:0] rows [6] = '{{REG_CTRL, 32'h0000_0000}, {REG_LVL_SP, 32'h0000_0000},
		{REG_PRS_SP, 32'h0000_FFFF}, {REG_STATUS, 32'h0000_0000},
		{REG_VLV_STAT, 32'h0000_0000}, {8'h3C, 32'h0000_0000}};

	////////////////////////////////////////////////////////////////////
	dal_top #(.LVL_CYC(TW'(LC)), .PRS_CYC(TW'(PC)),
		.GRP_T({TW'(4*GS), TW'(3*GS), TW'(2*GS), TW'(GS), TW'(0)})) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.level_i(level_i), .press_i(press_i), .div_lvl_vote_i(lv_i),
		.div_prs_vote_i(pv_i), .drv_fb_i(drv_fb_i), .cont_ok_i(cont_ok_i),
		.dis_sw_i(dis_sw_i), .vote_lvl_o(vote_lvl_o), .vote_prs_o(vote_prs_o),
		.lvl_init_o(lvl_init_o), .prs_init_o(prs_init_o), .drv_o(drv_o),
		.path_fire_o(path_fire_o), .arm_alarm_o(arm_alarm_o),
		.oos_alarm_o(oos_alarm_o), .bypass_ind_o(bypass_ind_o));
	dal_valve_unit u_vlv (.clk_i(clk_i), .drv_i(drv_o), .off_i(dis_req),
		.fb_o(drv_fb_i), .cont_o(cont_ok_i), .dis_o(dis_sw_i));

	// 125 mhz clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		rd = wb_dat_o;
		if (k >= 50) failures++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// whole cycles; stimulus lands on the edge, outputs read hold their pre-edge values
	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	task automatic do_rst;
		@(posedge clk_i);
		rst_i <= 1'b1;
		level_i <= '0;
		press_i <= '0;
		lv_i <= 4'h0;
		pv_i <= 4'h0;
		dis_req <= '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(1);
	endtask

	// bounded wait for an initiation output
	task automatic wait_init(input logic p);
		n = 0;
		while ((p ? prs_init_o : lvl_init_o) !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
	endtask

	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// a hang costs a mismatch, long past the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		do_rst();
		foreach (rows[i]) begin
			wb(1'b0, rows[i][39:32], 32'h0000_0000);
			chk("reg_rst", rd, rows[i][31:0]);
		end
		// write without sel[0] is ignored
		wb_sel_i <= 4'h0;
		wb(1'b1, REG_LVL_SP, 32'h0000_0100);
		wb_sel_i <= 4'h1;
		wb(1'b0, REG_LVL_SP, 32'h0000_0000);
		chk("sel_off", rd, 32'h0000_0000);
		// level trip: own vote alone, then an early drop, then held
		wb(1'b1, REG_LVL_SP, 32'h0000_0100);
		level_i <= {16'h0200, 16'h0200, 16'h0050};
		tick(6);
		chk("one_chan", vote_lvl_o, 1'h0);
		level_i <= {3{16'h0050}};
		tick(30);
		chk("vote_lvl", vote_lvl_o, 1'h1);
		chk("lvl_alone", lvl_init_o, 1'h0);
		lv_i <= 4'h2;
		tick(12);
		lv_i <= 4'h0;
		tick(5);
		lv_i <= 4'h2;
		tick(15);
		chk("lvl_restart", lvl_init_o, 1'h0);
		wait_init(1'b0);
		chk("lvl_time", n < 12, 1'h1);
		tick(4);
		chk("grp0", drv_o[2:0], 3'h3);
		chk("grp1_wait", drv_o[16:15], 2'h0);
		tick(8);
		chk("path0", path_fire_o[0], 1'h1);
		tick(4);
		chk("grp1", drv_o[16:15], 2'h3);
		tick(12);
		chk("grp2_squib", drv_o[32:30], 3'h7);
		chk("grp3_wait", drv_o[41:39], 3'h0);
		wb(1'b0, REG_STATUS, 32'h0000_0000);
		chk("lvl_latch", rd[8:6], 3'h7);
		chk("chan_agree", rd[2:0], 3'h7);
		dis_req[0] <= 1'b1;
		tick(6);
		chk("own_path", path_fire_o[1:0], 2'h2);
		chk("oos", oos_alarm_o, 1'h1);
		wb(1'b0, REG_OOS, 32'h0000_0000);
		chk("oos_reg", rd, 32'h0000_0001);
		// inhibit, then manual system initiation with an unarmed fire
		do_rst();
		wb(1'b1, REG_CTRL, 32'h0000_0001);
		wb(1'b1, REG_LVL_SP, 32'h0000_0100);
		level_i <= {3{16'h0050}};
		lv_i <= 4'h2;
		tick(60);
		chk("inhibit", |drv_o, 1'h0);
		wb(1'b1, REG_SYS_MAN, 32'h0000_0001);
		tick(2);
		chk("sys_arm_alarm", arm_alarm_o, 1'h1);
		wb(1'b1, REG_SYS_MAN, 32'h0000_0030);
		wb(1'b0, REG_SYS_MAN, 32'h0000_0000);
		chk("sys_one", rd[8:4], 5'h01);
		wb(1'b1, REG_SYS_MAN, 32'h0000_0002);
		wb(1'b1, REG_SYS_MAN, 32'h0000_0020);
		tick(4);
		chk("sys_init", drv_o[1:0], 2'h3);
		wb(1'b0, REG_SYS_MAN, 32'h0000_0000);
		chk("sys_seal", rd[8:4], 5'h13);
		// pressure trip with division 2 bypassed
		do_rst();
		wb(1'b1, REG_CTRL, 32'h0000_0050);
		wb(1'b1, REG_PRS_SP, 32'h0000_0200);
		press_i <= {3{16'h0300}};
		pv_i <= 4'h4;
		tick(60);
		chk("bypass_ind", bypass_ind_o, 4'h4);
		chk("vote_prs", vote_prs_o, 1'h1);
		chk("prs_byp", prs_init_o, 1'h0);
		pv_i <= 4'hC;
		wait_init(1'b1);
		chk("prs_time", n >= PC && n < PC + 8, 1'h1);
		tick(4);
		chk("prs_grp0", drv_o[1:0], 2'h3);
		// single valve: arm and fire together only arm
		do_rst();
		wb(1'b1, REG_VLV_MAN, 32'h0000_0303);
		tick(3);
		chk("one_step", |drv_o, 1'h0);
		chk("vlv_arm_alarm", arm_alarm_o, 1'h1);
		wb(1'b1, REG_VLV_MAN, 32'h0000_0200);
		tick(3);
		chk("man_fire", drv_o[10:9], 2'h3);
		// one driver exercised without opening its valve
		wb(1'b1, REG_DRV_TEST, 32'h0000_0403);
		tick(6);
		chk("drv_one", drv_o[14:12], 3'h2);
		chk("no_path", path_fire_o[4], 1'h0);
		wb(1'b0, REG_DRV_TEST, 32'h0000_0000);
		chk("drv_seen", rd[13:11], 3'h2);
		end_sim();
	end
endmodule

`default_nettype wire
